// >>> rtl/nrd_pkg.sv
// package for the nmi and reset distribution block
package nrd_pkg;
  localparam int unsigned NRD_NSRC = 7;
  localparam int unsigned NRD_AW = 8;
  localparam int unsigned NRD_DW = 32;
  // register offsets
  localparam logic [7:0] NRD_OFF_MNMI_FLAGS = 8'h00;
  localparam logic [7:0] NRD_OFF_MNMI_CLEAR = 8'h04;
  localparam logic [7:0] NRD_OFF_MNMI_FORCE = 8'h08;
  localparam logic [7:0] NRD_OFF_MNMI_WDOG = 8'h0C;
  localparam logic [7:0] NRD_OFF_CNMI_FLAGS = 8'h10;
  localparam logic [7:0] NRD_OFF_CNMI_CLEAR = 8'h14;
  localparam logic [7:0] NRD_OFF_CNMI_FORCE = 8'h18;
  localparam logic [7:0] NRD_OFF_CNMI_WDOG = 8'h1C;
  localparam logic [7:0] NRD_OFF_CTL_RESET_CONFIG = 8'h20;
  localparam logic [7:0] NRD_OFF_CTL_RESET_STATUS = 8'h24;
  localparam logic [7:0] NRD_OFF_PERIPH_SOFT_RESET = 8'h28;
  localparam logic [7:0] NRD_OFF_DEVICE_CONFIG = 8'h2C;
  localparam logic [7:0] NRD_OFF_MASTER_RESET_CAUSE = 8'h30;
  // master nmi source bits
  localparam int unsigned NRD_MSRC_CTL_WDOG = 0;
  localparam int unsigned NRD_MSRC_VECTOR = 1;
  localparam int unsigned NRD_MSRC_CLOCK = 2;
  localparam int unsigned NRD_MSRC_ABUS = 3;
  localparam int unsigned NRD_MSRC_EXTPIN = 4;
  localparam int unsigned NRD_MSRC_MST_ST = 5;
  localparam int unsigned NRD_MSRC_CTL_ST = 6;
  // control nmi source bits
  localparam int unsigned NRD_CSRC_CLOCK = 0;
  localparam int unsigned NRD_CSRC_ABUS = 1;
  localparam int unsigned NRD_CSRC_RAM = 2;
  localparam int unsigned NRD_CSRC_FLASH = 3;
  localparam int unsigned NRD_CSRC_VECTOR = 4;
  localparam int unsigned NRD_CSRC_CTL_ST = 5;
  localparam int unsigned NRD_CSRC_MST_ST = 6;
  // watchdog register bits
  localparam int unsigned NRD_WD_STOP_BIT = 0;
  localparam int unsigned NRD_WD_RUN_BIT = 0;
  localparam int unsigned NRD_WD_FIRED_BIT = 1;
  // control reset config bits
  localparam int unsigned NRD_CFG_SEL_CTL_RESET = 0;
  localparam int unsigned NRD_CFG_ANALOG_BUS_RESET = 1;
  localparam int unsigned NRD_CFG_PROPAGATE = 2;
  localparam logic [2:0] NRD_CFG_RESET = 3'h0;
  localparam int unsigned NRD_STS_CTL_IN_RESET = 0;
  // reset cause bits
  localparam int unsigned NRD_CAUSE_W = 6;
  localparam int unsigned NRD_CAUSE_EXT = 0;
  localparam int unsigned NRD_CAUSE_POR = 1;
  localparam int unsigned NRD_CAUSE_WD0 = 2;
  localparam int unsigned NRD_CAUSE_WD1 = 3;
  localparam int unsigned NRD_CAUSE_SW = 4;
  localparam int unsigned NRD_CAUSE_NMIWD = 5;
  localparam logic [5:0] NRD_CAUSE_RESET = 6'h02;
  // timing
  localparam int unsigned NRD_CLK_PERIOD_NS = 4;
  localparam int unsigned NRD_PIN_PULSE_NS = 32;
  localparam int unsigned NRD_PIN_PULSE_CYC =
    (NRD_PIN_PULSE_NS + NRD_CLK_PERIOD_NS - 1) / NRD_CLK_PERIOD_NS;
  localparam int unsigned NRD_NMI_WD_CYC = 65536;
  localparam int unsigned NRD_PULSE_W = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nrd_bus_s;

  typedef enum logic [2:0] {
    NRD_WD_IDLE = 3'b001,
    NRD_WD_RUN = 3'b010,
    NRD_WD_FIRE = 3'b100
  } nrd_wd_e;
endpackage : nrd_pkg

// >>> rtl/nrd_top.sv
// nmi units, nmi watchdogs and reset distribution
//
// Chosen here: the strobed register port and the register offsets.
module nrd_top #(
  parameter int unsigned NMI_WD_CYCLES = nrd_pkg::NRD_NMI_WD_CYC,
  parameter int unsigned N_PERIPH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire nrd_pkg::nrd_bus_s i_bus,
  output logic [31:0] o_rdata,
  input wire logic i_missing_clock_alarm,
  input wire logic i_analog_bus_error,
  input wire logic i_external_emergency_pin,
  input wire logic i_master_selftest_error,
  input wire logic i_control_selftest_error,
  input wire logic i_vector_fetch_error,
  input wire logic i_ram_uncorrectable_error,
  input wire logic i_flash_uncorrectable_error,
  input wire logic i_master_wdog0_timeout,
  input wire logic i_master_wdog1_timeout,
  input wire logic i_master_software_reset_n,
  input wire logic i_master_debugger_reset_n,
  input wire logic i_control_system_reset_n,
  input wire logic i_analog_power_on_reset_n,
  input wire logic i_main_reset_pin_n,
  output logic o_main_reset_pin_n,
  output logic o_main_reset_pin_oe,
  input wire logic i_analog_reset_pin_n,
  output logic o_analog_reset_pin_n,
  output logic o_analog_reset_pin_oe,
  output logic o_master_nmi_interrupt,
  output logic o_master_nmi_watchdog_event,
  output logic o_master_nmi_watchdog_reset,
  output logic o_control_nmi_interrupt,
  output logic o_control_nmi_watchdog_event,
  output logic o_control_nmi_watchdog_reset_n,
  output logic o_master_watchdog_reset_n,
  output logic o_master_system_reset_n,
  output logic o_master_cpu_reset_n,
  output logic [N_PERIPH-1:0] o_periph_reset_n,
  output logic o_control_cpu_reset_in_n,
  output logic o_analog_bus_reset,
  output logic o_analog_reset_n
);
  localparam int unsigned NS = nrd_pkg::NRD_NSRC;
  localparam int unsigned PW = nrd_pkg::NRD_PULSE_W;
  localparam logic [PW-1:0] PULSE = PW'(nrd_pkg::NRD_PIN_PULSE_CYC);
  localparam logic [31:0] WD_LOAD = 32'(NMI_WD_CYCLES);

  // set wins over clear
  function automatic logic [NS-1:0] flag_next(input logic [NS-1:0] cur,
      input logic [NS-1:0] src, input logic [NS-1:0] clr, input logic [NS-1:0] frc);
    flag_next = (cur & ~clr) | src | frc;
  endfunction : flag_next

  function automatic nrd_pkg::nrd_wd_e wd_next(input nrd_pkg::nrd_wd_e st,
      input logic evt, input logic stop, input logic last);
    case (st)
      nrd_pkg::NRD_WD_IDLE: wd_next = evt ? nrd_pkg::NRD_WD_RUN : nrd_pkg::NRD_WD_IDLE;
      nrd_pkg::NRD_WD_RUN: begin
        if (stop) begin
          wd_next = nrd_pkg::NRD_WD_IDLE;
        end else if (last) begin
          wd_next = nrd_pkg::NRD_WD_FIRE;
        end else begin
          wd_next = nrd_pkg::NRD_WD_RUN;
        end
      end
      default: wd_next = nrd_pkg::NRD_WD_IDLE;
    endcase
  endfunction : wd_next

  function automatic logic hit(input nrd_pkg::nrd_bus_s b, input logic [7:0] off);
    hit = (b.addr == off);
  endfunction : hit

  logic [NS-1:0] mflags_reg, mflags_next, msrc, mclr, mfrc;
  logic [NS-1:0] cflags_reg, cflags_next, csrc, cclr, cfrc;
  nrd_pkg::nrd_wd_e mwd_state_reg, cwd_state_reg;
  logic [31:0] mwd_cnt_reg, cwd_cnt_reg;
  logic mwd_fired_reg, cwd_fired_reg;
  logic m_evt, c_evt, m_stop, c_stop;
  logic [PW-1:0] pin_cnt_reg, ctl_cnt_reg;
  logic [2:0] cfg_reg;
  logic [N_PERIPH-1:0] peripheral_soft_reset_reg, dc_reg;
  logic [5:0] cause_reg, cause_set;
  logic pin_low, ext_low, swdbg, prop, wdog_comb, sysrst, ctlrst, anarst;

  // source mapping, self-test inputs from each core
  always_comb begin
    msrc = '0;
    msrc[nrd_pkg::NRD_MSRC_CTL_WDOG] = (ctl_cnt_reg != '0);
    msrc[nrd_pkg::NRD_MSRC_VECTOR] = i_vector_fetch_error;
    msrc[nrd_pkg::NRD_MSRC_CLOCK] = i_missing_clock_alarm;
    msrc[nrd_pkg::NRD_MSRC_ABUS] = i_analog_bus_error;
    msrc[nrd_pkg::NRD_MSRC_EXTPIN] = i_external_emergency_pin;
    msrc[nrd_pkg::NRD_MSRC_MST_ST] = i_master_selftest_error;
    msrc[nrd_pkg::NRD_MSRC_CTL_ST] = i_control_selftest_error;
    csrc = '0;
    csrc[nrd_pkg::NRD_CSRC_CLOCK] = i_missing_clock_alarm;
    csrc[nrd_pkg::NRD_CSRC_ABUS] = i_analog_bus_error;
    csrc[nrd_pkg::NRD_CSRC_RAM] = i_ram_uncorrectable_error;
    csrc[nrd_pkg::NRD_CSRC_FLASH] = i_flash_uncorrectable_error;
    csrc[nrd_pkg::NRD_CSRC_VECTOR] = i_vector_fetch_error;
    csrc[nrd_pkg::NRD_CSRC_CTL_ST] = i_control_selftest_error;
    csrc[nrd_pkg::NRD_CSRC_MST_ST] = i_master_selftest_error;
  end

  // write one acts, zero ignored
  always_comb begin
    mclr = (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MNMI_CLEAR)) ? i_bus.wdata[NS-1:0] : '0;
    mfrc = (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MNMI_FORCE)) ? i_bus.wdata[NS-1:0] : '0;
    cclr = (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_CNMI_CLEAR)) ? i_bus.wdata[NS-1:0] : '0;
    cfrc = (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_CNMI_FORCE)) ? i_bus.wdata[NS-1:0] : '0;
    m_stop = i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MNMI_WDOG)
      && i_bus.wdata[nrd_pkg::NRD_WD_STOP_BIT];
    c_stop = i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_CNMI_WDOG)
      && i_bus.wdata[nrd_pkg::NRD_WD_STOP_BIT];
    mflags_next = flag_next(mflags_reg, msrc, mclr, mfrc);
    cflags_next = flag_next(cflags_reg, csrc, cclr, cfrc);
    m_evt = (mflags_reg == '0) && (mflags_next != '0);
    c_evt = (cflags_reg == '0) && (cflags_next != '0);
  end

  // nmi flags and interrupt lines
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mflags_reg <= '0;
      cflags_reg <= '0;
      o_master_nmi_interrupt <= 1'b0;
      o_control_nmi_interrupt <= 1'b0;
      o_master_nmi_watchdog_event <= 1'b0;
      o_control_nmi_watchdog_event <= 1'b0;
    end else if (i_ce) begin
      mflags_reg <= mflags_next;
      cflags_reg <= cflags_next;
      o_master_nmi_interrupt <= |mflags_next;
      o_control_nmi_interrupt <= |cflags_next;
      o_master_nmi_watchdog_event <= m_evt;
      o_control_nmi_watchdog_event <= c_evt;
    end
  end

  // master nmi watchdog
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mwd_state_reg <= nrd_pkg::NRD_WD_IDLE;
      mwd_cnt_reg <= '0;
      mwd_fired_reg <= 1'b0;
    end else if (i_ce) begin
      mwd_state_reg <= wd_next(mwd_state_reg, m_evt, m_stop, mwd_cnt_reg == 32'h1);
      if (mwd_state_reg == nrd_pkg::NRD_WD_IDLE && m_evt) begin
        mwd_cnt_reg <= WD_LOAD;
      end else if (mwd_state_reg == nrd_pkg::NRD_WD_RUN && mwd_cnt_reg != '0) begin
        mwd_cnt_reg <= mwd_cnt_reg - 32'h1;
      end
      if (mwd_state_reg == nrd_pkg::NRD_WD_FIRE) begin
        mwd_fired_reg <= 1'b1;
      end
    end
  end

  // control nmi watchdog
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cwd_state_reg <= nrd_pkg::NRD_WD_IDLE;
      cwd_cnt_reg <= '0;
      cwd_fired_reg <= 1'b0;
    end else if (i_ce) begin
      cwd_state_reg <= wd_next(cwd_state_reg, c_evt, c_stop, cwd_cnt_reg == 32'h1);
      if (cwd_state_reg == nrd_pkg::NRD_WD_IDLE && c_evt) begin
        cwd_cnt_reg <= WD_LOAD;
      end else if (cwd_state_reg == nrd_pkg::NRD_WD_RUN && cwd_cnt_reg != '0) begin
        cwd_cnt_reg <= cwd_cnt_reg - 32'h1;
      end
      if (cwd_state_reg == nrd_pkg::NRD_WD_FIRE) begin
        cwd_fired_reg <= 1'b1;
      end
    end
  end

  // pin pulse after por and on watchdog timeouts; control watchdog reset stretch
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_cnt_reg <= PULSE;
      ctl_cnt_reg <= '0;
    end else if (i_ce) begin
      if (wdog_comb) begin
        pin_cnt_reg <= PULSE;
      end else if (pin_cnt_reg != '0) begin
        pin_cnt_reg <= pin_cnt_reg - PW'(1);
      end
      if (cwd_state_reg == nrd_pkg::NRD_WD_FIRE) begin
        ctl_cnt_reg <= PULSE;
      end else if (ctl_cnt_reg != '0) begin
        ctl_cnt_reg <= ctl_cnt_reg - PW'(1);
      end
    end
  end

  // reset combination
  always_comb begin
    wdog_comb = i_master_wdog0_timeout || i_master_wdog1_timeout
      || (mwd_state_reg == nrd_pkg::NRD_WD_FIRE);
    pin_low = !i_main_reset_pin_n || (pin_cnt_reg != '0);
    ext_low = !i_main_reset_pin_n && (pin_cnt_reg == '0);
    swdbg = !i_master_software_reset_n || !i_master_debugger_reset_n;
    prop = cfg_reg[nrd_pkg::NRD_CFG_PROPAGATE] && swdbg;
    sysrst = pin_low || wdog_comb || swdbg;
    ctlrst = pin_low || (ctl_cnt_reg != '0) || prop
      || cfg_reg[nrd_pkg::NRD_CFG_SEL_CTL_RESET];
    anarst = pin_low || prop || !i_analog_reset_pin_n
      || cfg_reg[nrd_pkg::NRD_CFG_ANALOG_BUS_RESET];
    cause_set = '0;
    cause_set[nrd_pkg::NRD_CAUSE_EXT] = ext_low;
    cause_set[nrd_pkg::NRD_CAUSE_WD0] = i_master_wdog0_timeout;
    cause_set[nrd_pkg::NRD_CAUSE_WD1] = i_master_wdog1_timeout;
    cause_set[nrd_pkg::NRD_CAUSE_SW] = swdbg;
    cause_set[nrd_pkg::NRD_CAUSE_NMIWD] = (mwd_state_reg == nrd_pkg::NRD_WD_FIRE);
  end

  // registered reset outputs, asserted from por except watchdog resets and pin enables
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_main_reset_pin_oe <= 1'b0;
      o_analog_reset_pin_oe <= 1'b0;
      o_master_nmi_watchdog_reset <= 1'b0;
      o_control_nmi_watchdog_reset_n <= 1'b1;
      o_master_watchdog_reset_n <= 1'b1;
      o_master_system_reset_n <= 1'b0;
      o_master_cpu_reset_n <= 1'b0;
      o_periph_reset_n <= '0;
      o_control_cpu_reset_in_n <= 1'b0;
      o_analog_bus_reset <= 1'b1;
      o_analog_reset_n <= 1'b0;
    end else if (i_ce) begin
      o_main_reset_pin_oe <= wdog_comb || (pin_cnt_reg > PW'(1));
      o_analog_reset_pin_oe <= !i_analog_power_on_reset_n;
      o_master_nmi_watchdog_reset <= (mwd_state_reg == nrd_pkg::NRD_WD_FIRE);
      o_control_nmi_watchdog_reset_n <= !((cwd_state_reg == nrd_pkg::NRD_WD_FIRE)
        || (ctl_cnt_reg > PW'(1)));
      o_master_watchdog_reset_n <= !wdog_comb;
      o_master_system_reset_n <= !sysrst;
      o_master_cpu_reset_n <= !sysrst;
      o_periph_reset_n <= ~(peripheral_soft_reset_reg & dc_reg) & {N_PERIPH{!sysrst}};
      o_control_cpu_reset_in_n <= !ctlrst;
      o_analog_bus_reset <= cfg_reg[nrd_pkg::NRD_CFG_ANALOG_BUS_RESET];
      o_analog_reset_n <= !anarst;
    end
  end
  assign o_main_reset_pin_n = 1'b0;
  assign o_analog_reset_pin_n = 1'b0;

  // software registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_reg <= nrd_pkg::NRD_CFG_RESET;
      peripheral_soft_reset_reg <= '0;
      dc_reg <= '0;
      cause_reg <= nrd_pkg::NRD_CAUSE_RESET;
    end else if (i_ce) begin
      if (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_CTL_RESET_CONFIG)) begin
        cfg_reg <= i_bus.wdata[2:0];
      end
      if (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_PERIPH_SOFT_RESET)) begin
        peripheral_soft_reset_reg <= i_bus.wdata[N_PERIPH-1:0];
      end
      if (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_DEVICE_CONFIG)) begin
        dc_reg <= i_bus.wdata[N_PERIPH-1:0];
      end
      if (i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MASTER_RESET_CAUSE)) begin
        cause_reg <= (cause_reg & ~i_bus.wdata[5:0]) | cause_set;
      end else begin
        cause_reg <= cause_reg | cause_set;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_bus.rd) begin
        if (hit(i_bus, nrd_pkg::NRD_OFF_MNMI_FLAGS)) begin
          o_rdata <= 32'(mflags_reg);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_CNMI_FLAGS)) begin
          o_rdata <= 32'(cflags_reg);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_MNMI_WDOG)) begin
          o_rdata <= 32'({mwd_fired_reg, mwd_state_reg == nrd_pkg::NRD_WD_RUN});
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_CNMI_WDOG)) begin
          o_rdata <= 32'({cwd_fired_reg, cwd_state_reg == nrd_pkg::NRD_WD_RUN});
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_CTL_RESET_CONFIG)) begin
          o_rdata <= 32'(cfg_reg);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_CTL_RESET_STATUS)) begin
          o_rdata <= 32'(!i_control_system_reset_n);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_PERIPH_SOFT_RESET)) begin
          o_rdata <= 32'(peripheral_soft_reset_reg);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_DEVICE_CONFIG)) begin
          o_rdata <= 32'(dc_reg);
        end else if (hit(i_bus, nrd_pkg::NRD_OFF_MASTER_RESET_CAUSE)) begin
          o_rdata <= 32'(cause_reg);
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_mflag_rise;
    i_ce && (mflags_reg == '0) && i_vector_fetch_error;
  endsequence
  sequence s_cwd_fire;
    i_ce && (cwd_state_reg == nrd_pkg::NRD_WD_FIRE) ##1 i_ce;
  endsequence

  AST_MNMI_RAISE: assert property (s_mflag_rise |=> o_master_nmi_interrupt && o_master_nmi_watchdog_event && mwd_state_reg == nrd_pkg::NRD_WD_RUN) else $error("master nmi not raised");
  AST_CNMI_RAISE: assert property (i_ce && i_ram_uncorrectable_error |=> o_control_nmi_interrupt && cflags_reg[nrd_pkg::NRD_CSRC_RAM]) else $error("control nmi not raised");
  AST_MWD_PIN: assert property (i_ce && mwd_state_reg == nrd_pkg::NRD_WD_FIRE |=> o_main_reset_pin_oe && !o_master_system_reset_n && o_master_nmi_watchdog_reset) else $error("master nmi watchdog reset missing");
  AST_CWD_FLAG: assert property (s_cwd_fire |=> mflags_reg[nrd_pkg::NRD_MSRC_CTL_WDOG] && !o_control_cpu_reset_in_n) else $error("control watchdog reset not passed on");
  AST_CLEAR: assert property (i_ce && i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MNMI_CLEAR) && i_bus.wdata[nrd_pkg::NRD_MSRC_CLOCK] && !i_missing_clock_alarm |=> !mflags_reg[nrd_pkg::NRD_MSRC_CLOCK]) else $error("flag clear failed");
  AST_FORCE: assert property (i_ce && i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_CNMI_FORCE) && i_bus.wdata[nrd_pkg::NRD_CSRC_FLASH] |=> cflags_reg[nrd_pkg::NRD_CSRC_FLASH] [*2]) else $error("flag force failed");
  AST_STICKY: assert property (i_ce && mflags_reg[nrd_pkg::NRD_MSRC_EXTPIN] && !(i_bus.wr && hit(i_bus, nrd_pkg::NRD_OFF_MNMI_CLEAR)) |=> mflags_reg[nrd_pkg::NRD_MSRC_EXTPIN]) else $error("flag dropped without clear");
  AST_RD_ZERO: assert property (i_ce && i_bus.rd && (hit(i_bus, nrd_pkg::NRD_OFF_MNMI_FORCE) || hit(i_bus, nrd_pkg::NRD_OFF_CNMI_CLEAR)) |=> o_rdata == '0) else $error("clear or force read not zero");
  AST_PIN_RESET: assert property (i_ce && !i_main_reset_pin_n |=> !o_master_system_reset_n && !o_control_cpu_reset_in_n && !o_analog_reset_n) else $error("pin reset not distributed");
  AST_SW_SYSRST: assert property (i_ce && !i_master_software_reset_n |=> !o_master_system_reset_n && !o_master_cpu_reset_n && o_periph_reset_n == '0) else $error("software reset missed");
  AST_PROP_GATE: assert property (i_ce && !i_master_debugger_reset_n && i_main_reset_pin_n && pin_cnt_reg == '0 && ctl_cnt_reg == '0 && cfg_reg == '0 |=> o_control_cpu_reset_in_n) else $error("debugger reset leaked to control");
  AST_SEL_CTL: assert property (i_ce && cfg_reg[nrd_pkg::NRD_CFG_SEL_CTL_RESET] |=> !o_control_cpu_reset_in_n) else $error("selective control reset missing");
  AST_PERIPH: assert property (i_ce && peripheral_soft_reset_reg[0] && !dc_reg[0] && !sysrst |=> o_periph_reset_n[0]) else $error("disabled peripheral was reset");
  AST_CAUSE_WD0: assert property (i_ce && i_master_wdog0_timeout |=> cause_reg[nrd_pkg::NRD_CAUSE_WD0] && !o_master_watchdog_reset_n) else $error("watchdog 0 cause not recorded");
endmodule : nrd_top

// >>> tb/nrd_far_side.sv
// far side model: pulled-up main reset wire and board power-up hold
module nrd_far_side (
  input wire logic i_arst_n,
  input wire logic i_hold_req,
  input wire logic i_pin_oe,
  output logic o_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // low while any party pulls it, held low through power-up
  assign o_pin_n = !(i_pin_oe || i_hold_req || !i_arst_n);
endmodule : nrd_far_side

// >>> tb/nrd_top_bench.sv
// self-checking bench for the nmi and reset distribution block
module nrd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold = 1'b0;
  logic sw_n = 1'b1;
  logic wd0 = 1'b0;
  logic csys_n = 1'b1;
  logic [7:0] src = 8'h00;
  nrd_pkg::nrd_bus_s bus = '0;
  logic [31:0] rdata, d;
  logic pin_n, pin_oe, mint, cint, mwdr, cwdr_n, msys_n, ccpu_n, abr;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  nrd_far_side u_nrd_far_side (.i_arst_n(rst_n), .i_hold_req(hold), .i_pin_oe(pin_oe),
    .o_pin_n(pin_n));
  nrd_top #(.NMI_WD_CYCLES(8)) u_nrd_top (.i_ref_clk(clk), .i_arst_n(rst_n), .i_ce(1'b1),
    .i_bus(bus), .o_rdata(rdata), .i_missing_clock_alarm(src[0]), .i_analog_bus_error(src[1]),
    .i_external_emergency_pin(src[2]), .i_master_selftest_error(src[3]),
    .i_control_selftest_error(src[4]), .i_vector_fetch_error(src[5]),
    .i_ram_uncorrectable_error(src[6]), .i_flash_uncorrectable_error(src[7]),
    .i_master_wdog0_timeout(wd0), .i_master_wdog1_timeout(1'b0),
    .i_master_software_reset_n(sw_n), .i_master_debugger_reset_n(1'b1),
    .i_control_system_reset_n(csys_n), .i_analog_power_on_reset_n(1'b1),
    .i_main_reset_pin_n(pin_n), .o_main_reset_pin_n(), .o_main_reset_pin_oe(pin_oe),
    .i_analog_reset_pin_n(pin_n), .o_analog_reset_pin_n(), .o_analog_reset_pin_oe(),
    .o_master_nmi_interrupt(mint), .o_master_nmi_watchdog_event(),
    .o_master_nmi_watchdog_reset(mwdr), .o_control_nmi_interrupt(cint),
    .o_control_nmi_watchdog_event(), .o_control_nmi_watchdog_reset_n(cwdr_n),
    .o_master_watchdog_reset_n(), .o_master_system_reset_n(msys_n), .o_master_cpu_reset_n(),
    .o_periph_reset_n(), .o_control_cpu_reset_in_n(ccpu_n), .o_analog_bus_reset(abr),
    .o_analog_reset_n());
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
    #1 d = rdata;
  endtask : acc
  task automatic await(ref logic s, input logic v, input string n);
    int k = 0;
    while (s !== v && k < 60) begin
      @(posedge clk);
      #1 k++;
    end
    chk(n, 32'(v), 32'(s));
  endtask : await
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_force;
    acc(1'b1, nrd_pkg::NRD_OFF_MNMI_FORCE, 32'h48);
    acc(1'b0, nrd_pkg::NRD_OFF_MNMI_FLAGS, 32'h0);
    chk("mflags", 32'h48, d);
    chk("mint", 32'h1, 32'(mint));
    acc(1'b1, nrd_pkg::NRD_OFF_MNMI_WDOG, 32'h1);
    acc(1'b0, nrd_pkg::NRD_OFF_MNMI_FORCE, 32'h0);
    chk("frc_rd", 32'h0, d);
    acc(1'b1, nrd_pkg::NRD_OFF_MNMI_CLEAR, 32'h40);
    acc(1'b0, nrd_pkg::NRD_OFF_MNMI_FLAGS, 32'h0);
    chk("mflags_clr", 32'h08, d);
    acc(1'b1, nrd_pkg::NRD_OFF_MNMI_CLEAR, 32'h08);
    $display("t_force done");
  endtask : t_force
  task automatic t_srcs;
    logic [7:0] em [8] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h02, 8'h00, 8'h00};
    logic [7:0] ec [8] = '{8'h01, 8'h02, 8'h00, 8'h40, 8'h20, 8'h10, 8'h04, 8'h08};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      src <= 8'h01 << i;
      @(posedge clk);
      src <= 8'h00;
      acc(1'b1, nrd_pkg::NRD_OFF_MNMI_WDOG, 32'h1);
      acc(1'b1, nrd_pkg::NRD_OFF_CNMI_WDOG, 32'h1);
      acc(1'b0, nrd_pkg::NRD_OFF_MNMI_FLAGS, 32'h0);
      chk("mflags_src", {24'h0, em[i]}, d);
      acc(1'b0, nrd_pkg::NRD_OFF_CNMI_FLAGS, 32'h0);
      chk("cflags_src", {24'h0, ec[i]}, d);
      chk("cint", 32'(ec[i] != 8'h00), 32'(cint));
      acc(1'b1, nrd_pkg::NRD_OFF_MNMI_CLEAR, 32'h7F);
      acc(1'b1, nrd_pkg::NRD_OFF_CNMI_CLEAR, 32'h7F);
    end
    $display("t_srcs done");
  endtask : t_srcs
  task automatic t_chain;
    @(posedge clk);
    src <= 8'h40;
    @(posedge clk);
    src <= 8'h00;
    await(cwdr_n, 1'b0, "cwd_rst");
    @(posedge clk);
    #1 chk("ccpu_cwd", 32'h0, 32'(ccpu_n));
    acc(1'b0, nrd_pkg::NRD_OFF_MNMI_FLAGS, 32'h0);
    chk("mflags_cwd", 32'h01, d);
    await(mwdr, 1'b1, "mwd_rst");
    await(pin_oe, 1'b1, "pin_drive");
    await(msys_n, 1'b0, "msys_wd");
    repeat (40) @(posedge clk);
    acc(1'b1, nrd_pkg::NRD_OFF_MNMI_CLEAR, 32'h7F);
    acc(1'b1, nrd_pkg::NRD_OFF_CNMI_CLEAR, 32'h7F);
    $display("t_chain done");
  endtask : t_chain
  task automatic t_resets;
    @(posedge clk) hold <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("msys_pin", 32'h0, 32'(msys_n));
    chk("ccpu_pin", 32'h0, 32'(ccpu_n));
    @(posedge clk) hold <= 1'b0;
    repeat (30) @(posedge clk);
    acc(1'b1, nrd_pkg::NRD_OFF_CTL_RESET_CONFIG, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("ccpu_sel", 32'h0, 32'(ccpu_n));
    chk("abus_rst", 32'h1, 32'(abr));
    @(posedge clk) csys_n <= 1'b0;
    acc(1'b0, nrd_pkg::NRD_OFF_CTL_RESET_STATUS, 32'h0);
    chk("ctl_sts", 32'h1, d);
    acc(1'b1, nrd_pkg::NRD_OFF_CTL_RESET_CONFIG, 32'h4);
    @(posedge clk) sw_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("ccpu_sw", 32'h0, 32'(ccpu_n));
    chk("msys_sw", 32'h0, 32'(msys_n));
    @(posedge clk) sw_n <= 1'b1;
    repeat (40) @(posedge clk);
    wd0 <= 1'b1;
    @(posedge clk) wd0 <= 1'b0;
    #1 chk("msys_wd0", 32'h0, 32'(msys_n));
    chk("pin_wd0", 32'h1, 32'(pin_oe));
    repeat (40) @(posedge clk);
    acc(1'b0, nrd_pkg::NRD_OFF_MASTER_RESET_CAUSE, 32'h0);
    chk("cause_sw", 32'h1, 32'(d[nrd_pkg::NRD_CAUSE_SW]));
    chk("cause_por", 32'h1, 32'(d[nrd_pkg::NRD_CAUSE_POR]));
    chk("cause_wd0", 32'h1, 32'(d[nrd_pkg::NRD_CAUSE_WD0]));
    $display("t_resets done");
  endtask : t_resets
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    t_force();
    t_srcs();
    t_chain();
    t_resets();
    tally_and_finish();
  end
endmodule : nrd_top_bench
